/* File: verilog/rpm_pkg.sv */
package rpm_pkg;
   // Oscillator clocks per machine cycle
   localparam int RPM_CLKS_PER_MCYCLE = 12;
   // Machine cycles the reset pin must stay high
   localparam int RPM_RST_MCYCLES = 2;
   // Oscillator clocks the reset pin must stay high
   localparam int RPM_RST_HOLD_CLKS = RPM_RST_MCYCLES * RPM_CLKS_PER_MCYCLE;
   localparam int RPM_CNT_W = 5;
   localparam logic [RPM_CNT_W-1:0] RPM_RST_HOLD_LAST = 5'(RPM_RST_HOLD_CLKS - 1);
   // Reset vector of the program counter
   localparam logic [15:0] RPM_RESET_VECTOR = 16'h0000;
   // On-chip RAM geometry
   localparam int RPM_RAM_DEPTH = 256;
   localparam int RPM_RAM_AW = 8;
   localparam int RPM_RAM_DW = 8;
   // Reset values of the power control bits
   localparam logic RPM_IDLE_RST = 1'b0;
   localparam logic RPM_PD_RST = 1'b0;
   // Strobe levels
   localparam logic RPM_STROBE_HIGH = 1'b1;
   localparam logic RPM_STROBE_LOW = 1'b0;

   typedef enum logic [1:0] {
      RPM_ST_RESET = 2'b00,
      RPM_ST_ACTIVE = 2'b01,
      RPM_ST_IDLE = 2'b10,
      RPM_ST_PDOWN = 2'b11
   } rpm_state_t;
endpackage

/* File: verilog/rpm_ram.sv */
`timescale 1ns/10ps
`default_nettype none
// Retained data RAM; no reset so contents survive a running reset
module rpm_ram #(
   parameter int DEPTH = 256,
   parameter int AW = 8,
   parameter int DW = 8
) (
   input wire logic clk_in,
   input wire logic we_in,
   input wire logic [AW-1:0] addr_in,
   input wire logic [DW-1:0] wdata_in,
   output logic [DW-1:0] rdata_out
);
   logic [DW-1:0] mem [0:DEPTH-1];

   // Write port
   always_ff @(posedge clk_in) begin
      if (we_in) begin
         mem[addr_in] <= wdata_in;
      end
   end

   // Registered read port
   always_ff @(posedge clk_in) begin
      rdata_out <= mem[addr_in];
   end
endmodule
`default_nettype wire

/* File: verilog/rpm_top.sv */
`timescale 1ns/10ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Function
// - Reset restarts execution at address zero
// - Strobes weakly high during reset
// - Reset never disturbs on-chip RAM
// - Reset loads all register reset values
// - Power-up reset drives ones on ports
// - Idle stops program counter, clocks keep running
// - Interrupt clears idle bit, resumes next
// - Reset exits idle or power-down fully
// - Idle drives both strobes high
// - Power-down stops clock, level interrupts wake
// - Level interrupt clears power-down bit, resumes
// - Power-down drives both strobes low
// - Standby freezes all state until clock
// - Standby holds strobes at prior levels
module rpm_top
   import rpm_pkg::*;
#(
   parameter int RAM_DEPTH = RPM_RAM_DEPTH,
   parameter int RAM_AW = RPM_RAM_AW,
   parameter int RAM_DW = RPM_RAM_DW
) (
   input wire logic mclk_in,
   input wire logic sys_rst_in,
   input wire logic reset_pin_in,
   input wire logic ext_level_irq_in,
   input wire logic enabled_irq_in,
   input wire logic idle_set_in,
   input wire logic pd_set_in,
   input wire logic addr_latch_strobe_core_in,
   input wire logic program_store_strobe_n_core_in,
   input wire logic ram_we_in,
   input wire logic [RAM_AW-1:0] ram_addr_in,
   input wire logic [RAM_DW-1:0] ram_wdata_in,
   output logic [RAM_DW-1:0] ram_rdata_out,
   output logic core_rst_out,
   output logic [15:0] pc_vector_out,
   output logic pc_run_out,
   output logic core_clk_en_out,
   output logic periph_clk_en_out,
   output logic port_force_ones_out,
   output logic idle_request_bit_out,
   output logic powerdown_request_bit_out,
   output logic wake_out,
   output logic addr_latch_strobe_out,
   output logic program_store_strobe_n_out,
   output logic strobe_weak_out
);
   rpm_state_t state;
   rpm_state_t next_state;
   logic [2:0] rst_sync;
   logic rst_filt;
   logic [2:0] irq_sync;
   logic irq_filt;
   logic [RPM_CNT_W-1:0] hold_cnt;
   logic pin_reset;
   logic idle_bit;
   logic pd_bit;
   logic next_idle_bit;
   logic next_pd_bit;
   logic ram_we_ok;

   //////////////////////////////////////////////////////////////////////////
   // Pin synchronisers: three stages, change taken when last two agree
   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         rst_sync <= 3'h0;
         rst_filt <= 1'b0;
      end else begin
         rst_sync <= {rst_sync[1:0], reset_pin_in};
         if (rst_sync[1] == rst_sync[2]) begin
            rst_filt <= rst_sync[2];
         end
      end
   end

   // Wake source runs on the same clock because power-down here only gates the core and peripheral clock enables
   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         irq_sync <= 3'h0;
         irq_filt <= 1'b0;
      end else begin
         irq_sync <= {irq_sync[1:0], ext_level_irq_in};
         if (irq_sync[1] == irq_sync[2]) begin
            irq_filt <= irq_sync[2];
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Reset pin qualifier; short glitches never reach the core
   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         hold_cnt <= '0;
         pin_reset <= 1'b0;
      end else if (!rst_filt) begin
         hold_cnt <= '0;
         pin_reset <= 1'b0;
      end else if (hold_cnt == RPM_RST_HOLD_LAST) begin
         pin_reset <= 1'b1;
      end else begin
         hold_cnt <= hold_cnt + 1'b1;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Power control bits; hardware wake clears win over a software set
   always_comb begin
      next_idle_bit = idle_bit;
      next_pd_bit = pd_bit;
      if (state == RPM_ST_ACTIVE) begin
         if (idle_set_in) begin
            next_idle_bit = 1'b1;
         end
         if (pd_set_in) begin
            next_pd_bit = 1'b1;
         end
      end
      if (state == RPM_ST_IDLE && enabled_irq_in) begin
         next_idle_bit = 1'b0;
      end
      if (state == RPM_ST_PDOWN && irq_filt) begin
         next_pd_bit = 1'b0;
      end
   end

   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         idle_bit <= RPM_IDLE_RST;
         pd_bit <= RPM_PD_RST;
      end else if (pin_reset) begin
         idle_bit <= RPM_IDLE_RST;
         pd_bit <= RPM_PD_RST;
      end else begin
         idle_bit <= next_idle_bit;
         pd_bit <= next_pd_bit;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Mode sequencer; power-down takes priority when both bits are set
   always_comb begin
      next_state = state;
      case (state)
         RPM_ST_RESET: begin
            next_state = RPM_ST_ACTIVE;
         end
         RPM_ST_ACTIVE: begin
            if (pd_set_in) begin
               next_state = RPM_ST_PDOWN;
            end else if (idle_set_in) begin
               next_state = RPM_ST_IDLE;
            end
         end
         RPM_ST_IDLE: begin
            if (enabled_irq_in) begin
               next_state = RPM_ST_ACTIVE;
            end
         end
         RPM_ST_PDOWN: begin
            if (irq_filt) begin
               next_state = RPM_ST_ACTIVE;
            end
         end
         default: begin
            next_state = RPM_ST_RESET;
         end
      endcase
   end

   // A qualified pin reset overrides every mode, just like power-on
   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         state <= RPM_ST_RESET;
      end else if (pin_reset) begin
         state <= RPM_ST_RESET;
      end else begin
         state <= next_state;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Core controls; clock gating of mclk by outside logic simply freezes these
   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         core_rst_out <= 1'b1;
         pc_vector_out <= RPM_RESET_VECTOR;
         pc_run_out <= 1'b0;
         core_clk_en_out <= 1'b0;
         periph_clk_en_out <= 1'b0;
         port_force_ones_out <= 1'b1;
         wake_out <= 1'b0;
      end else begin
         core_rst_out <= pin_reset || next_state == RPM_ST_RESET;
         pc_vector_out <= RPM_RESET_VECTOR;
         pc_run_out <= !pin_reset && next_state == RPM_ST_ACTIVE;
         core_clk_en_out <= !pin_reset && next_state != RPM_ST_PDOWN;
         periph_clk_en_out <= !pin_reset && next_state != RPM_ST_PDOWN;
         port_force_ones_out <= pin_reset || next_state == RPM_ST_RESET;
         wake_out <= !pin_reset && next_state == RPM_ST_ACTIVE &&
                     (state == RPM_ST_IDLE || state == RPM_ST_PDOWN);
      end
   end

   // Visible copies of the power control bits
   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         idle_request_bit_out <= RPM_IDLE_RST;
         powerdown_request_bit_out <= RPM_PD_RST;
      end else begin
         idle_request_bit_out <= pin_reset ? RPM_IDLE_RST : next_idle_bit;
         powerdown_request_bit_out <= pin_reset ? RPM_PD_RST : next_pd_bit;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Strobes; held in flops so a stopped clock keeps the last levels
   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         addr_latch_strobe_out <= RPM_STROBE_HIGH;
         program_store_strobe_n_out <= RPM_STROBE_HIGH;
         strobe_weak_out <= 1'b1;
      end else if (pin_reset || next_state == RPM_ST_RESET) begin
         addr_latch_strobe_out <= RPM_STROBE_HIGH;
         program_store_strobe_n_out <= RPM_STROBE_HIGH;
         strobe_weak_out <= 1'b1;
      end else begin
         strobe_weak_out <= 1'b0;
         case (next_state)
            RPM_ST_IDLE: begin
               addr_latch_strobe_out <= RPM_STROBE_HIGH;
               program_store_strobe_n_out <= RPM_STROBE_HIGH;
            end
            RPM_ST_PDOWN: begin
               addr_latch_strobe_out <= RPM_STROBE_LOW;
               program_store_strobe_n_out <= RPM_STROBE_LOW;
            end
            default: begin
               addr_latch_strobe_out <= addr_latch_strobe_core_in;
               program_store_strobe_n_out <= program_store_strobe_n_core_in;
            end
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // RAM writes only while running; reset and power-down keep contents
   assign ram_we_ok = ram_we_in && !pin_reset && state == RPM_ST_ACTIVE;

   rpm_ram #(
      .DEPTH(RAM_DEPTH),
      .AW(RAM_AW),
      .DW(RAM_DW)
   ) u_ram (
      .clk_in(mclk_in),
      .we_in(ram_we_ok),
      .addr_in(ram_addr_in),
      .wdata_in(ram_wdata_in),
      .rdata_out(ram_rdata_out)
   );
endmodule
`default_nettype wire

/* File: testbench/rpm_chk_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
module rpm_chk (
   input wire logic mclk_in,
   input wire logic sys_rst_in,
   input wire logic reset_pin_in,
   input wire logic ext_level_irq_in,
   input wire logic enabled_irq_in,
   input wire logic idle_set_in,
   input wire logic pd_set_in,
   input wire logic core_rst_out,
   input wire logic [15:0] pc_vector_out,
   input wire logic pc_run_out,
   input wire logic core_clk_en_out,
   input wire logic periph_clk_en_out,
   input wire logic port_force_ones_out,
   input wire logic idle_request_bit_out,
   input wire logic powerdown_request_bit_out,
   input wire logic wake_out,
   input wire logic addr_latch_strobe_out,
   input wire logic program_store_strobe_n_out,
   input wire logic strobe_weak_out
);
   logic [5:0] pin_cnt;
   default clocking @(posedge mclk_in); endclocking
   default disable iff (sys_rst_in);
   //////////////////////////////////////////////////////////////////////////////
   // Pin high time; saturates so a long hold never wraps
   always_ff @(posedge mclk_in or posedge sys_rst_in)
      if (sys_rst_in) pin_cnt <= 6'h00;
      else if (!reset_pin_in) pin_cnt <= 6'h00;
      else if (pin_cnt != 6'h3F) pin_cnt <= pin_cnt + 6'h01;
   //////////////////////////////////////////////////////////////////////////////
   a_pin_reset: assert property (pin_cnt >= 6'h20 |-> core_rst_out) else $error("pin reset");
   a_rst_values: assert property (core_rst_out |-> strobe_weak_out && port_force_ones_out
      && addr_latch_strobe_out && program_store_strobe_n_out && !pc_run_out && pc_vector_out == 16'h0000
      && !idle_request_bit_out && !powerdown_request_bit_out) else $error("reset values");
   a_idle_entry: assert property (idle_set_in && !pd_set_in && pc_run_out && !core_rst_out
      |=> idle_request_bit_out && !pc_run_out && periph_clk_en_out) else $error("idle entry");
   a_idle_wake: assert property (idle_request_bit_out && !powerdown_request_bit_out && enabled_irq_in
      && !core_rst_out |=> !idle_request_bit_out && wake_out && pc_run_out) else $error("idle wake");
   a_idle_strobes: assert property (idle_request_bit_out && !powerdown_request_bit_out
      |-> addr_latch_strobe_out && program_store_strobe_n_out) else $error("idle strobes");
   a_pd_entry: assert property (pd_set_in && pc_run_out && !core_rst_out
      |=> powerdown_request_bit_out && !core_clk_en_out && !periph_clk_en_out) else $error("pd entry");
   a_pd_stay: assert property (!ext_level_irq_in [*5] ##0 powerdown_request_bit_out
      |=> powerdown_request_bit_out || core_rst_out) else $error("pd left");
   a_pd_wake: assert property ($rose(ext_level_irq_in) && powerdown_request_bit_out
      |-> ##[1:8] (wake_out && core_clk_en_out)) else $error("pd wake");
   a_pd_strobes: assert property (powerdown_request_bit_out
      |-> !addr_latch_strobe_out && !program_store_strobe_n_out) else $error("pd strobes");
   a_wake_pulse: assert property (wake_out |=> !wake_out) else $error("wake pulse");
endmodule
bind rpm_top rpm_chk u_chk (
   .mclk_in(mclk_in),
   .sys_rst_in(sys_rst_in),
   .reset_pin_in(reset_pin_in),
   .ext_level_irq_in(ext_level_irq_in),
   .enabled_irq_in(enabled_irq_in),
   .idle_set_in(idle_set_in),
   .pd_set_in(pd_set_in),
   .core_rst_out(core_rst_out),
   .pc_vector_out(pc_vector_out),
   .pc_run_out(pc_run_out),
   .core_clk_en_out(core_clk_en_out),
   .periph_clk_en_out(periph_clk_en_out),
   .port_force_ones_out(port_force_ones_out),
   .idle_request_bit_out(idle_request_bit_out),
   .powerdown_request_bit_out(powerdown_request_bit_out),
   .wake_out(wake_out),
   .addr_latch_strobe_out(addr_latch_strobe_out),
   .program_store_strobe_n_out(program_store_strobe_n_out),
   .strobe_weak_out(strobe_weak_out)
);
`default_nettype wire

/* File: testbench/rpm_ext.sv */
`timescale 1ns/10ps
`default_nettype none
// Board side: clock gate and reset stretcher
module rpm_ext (
   input wire logic osc_in,
   input wire logic gate_in,
   input wire logic pin_req_in,
   output logic mclk_out,
   output logic pin_out
);
   logic run = 1'h1;
   logic [5:0] hold = 6'h00;
   // Gate moves only while the oscillator is low, so no runt pulse
   always @(negedge osc_in) run <= !gate_in;
   assign mclk_out = osc_in & run;
   // Stretch a request well past the 24-clock minimum
   always @(posedge osc_in) hold <= pin_req_in ? 6'h28 : (hold != 6'h00) ? hold - 6'h01 : hold;
   assign pin_out = pin_req_in | (hold != 6'h00);
endmodule
`default_nettype wire

/* File: testbench/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin num_errors++; $display("mismatch t=%0t got=%h exp=%h", $time, a, e); end end
module testbench;
   import rpm_pkg::*;
   logic osc_clk = 1'h0, gate = 1'h0, pin_req = 1'h0, mclk_in, reset_pin_in;
   logic sys_rst_in = 1'h1, ext_level_irq_in = 1'h0, enabled_irq_in = 1'h0, idle_set_in = 1'h0, pd_set_in = 1'h0;
   logic addr_latch_strobe_core_in = 1'h0, program_store_strobe_n_core_in = 1'h1, ram_we_in = 1'h0;
   logic [7:0] ram_addr_in = 8'h5A, ram_wdata_in = 8'hC3, ram_rdata_out;
   logic core_rst_out, pc_run_out, core_clk_en_out, periph_clk_en_out, port_force_ones_out, wake_out;
   logic idle_request_bit_out, powerdown_request_bit_out, addr_latch_strobe_out;
   logic program_store_strobe_n_out, strobe_weak_out;
   logic [15:0] pc_vector_out;
   int num_errors = 0;
   int cmp_count = 0;
   rpm_ext u_ext (.osc_in(osc_clk), .gate_in(gate), .pin_req_in(pin_req), .mclk_out(mclk_in), .pin_out(reset_pin_in));
   rpm_top u_dut (
      .mclk_in(mclk_in),
      .sys_rst_in(sys_rst_in),
      .reset_pin_in(reset_pin_in),
      .ext_level_irq_in(ext_level_irq_in),
      .enabled_irq_in(enabled_irq_in),
      .idle_set_in(idle_set_in),
      .pd_set_in(pd_set_in),
      .addr_latch_strobe_core_in(addr_latch_strobe_core_in),
      .program_store_strobe_n_core_in(program_store_strobe_n_core_in),
      .ram_we_in(ram_we_in),
      .ram_addr_in(ram_addr_in),
      .ram_wdata_in(ram_wdata_in),
      .ram_rdata_out(ram_rdata_out),
      .core_rst_out(core_rst_out),
      .pc_vector_out(pc_vector_out),
      .pc_run_out(pc_run_out),
      .core_clk_en_out(core_clk_en_out),
      .periph_clk_en_out(periph_clk_en_out),
      .port_force_ones_out(port_force_ones_out),
      .idle_request_bit_out(idle_request_bit_out),
      .powerdown_request_bit_out(powerdown_request_bit_out),
      .wake_out(wake_out),
      .addr_latch_strobe_out(addr_latch_strobe_out),
      .program_store_strobe_n_out(program_store_strobe_n_out),
      .strobe_weak_out(strobe_weak_out)
   );
   //////////////////////////////////////////////////////////////////////////////
   task automatic tick(input int n);
      repeat (n) @(negedge osc_clk);
   endtask
   task automatic pulse_pin();
      pin_req = 1'h1;
      tick(1);
      pin_req = 1'h0;
      repeat (80) if (core_rst_out !== 1'h1) tick(1);
      `CHK({core_rst_out, idle_request_bit_out, powerdown_request_bit_out, pc_run_out}, 4'h8)
      repeat (200) if (core_rst_out !== 1'h0) tick(1);
      tick(2);
   endtask
   // Held power-on reset, then the first active cycles
   task automatic t_reset();
      tick(10);
      `CHK({core_rst_out, strobe_weak_out, port_force_ones_out}, 3'h7)
      `CHK({addr_latch_strobe_out, program_store_strobe_n_out}, 2'h3)
      `CHK(pc_vector_out, RPM_RESET_VECTOR)
      sys_rst_in = 1'h0;
      tick(2);
      `CHK({core_rst_out, pc_run_out, idle_request_bit_out, powerdown_request_bit_out}, 4'h4)
   endtask
   // A byte written before a pin reset is still there after it
   task automatic t_ram();
      ram_we_in = 1'h1;
      tick(1);
      ram_we_in = 1'h0;
      tick(2);
      `CHK(ram_rdata_out, 8'hC3)
      pulse_pin();
      `CHK(ram_rdata_out, 8'hC3)
   endtask
   // Idle, interrupt wake, then idle left by a pin reset
   task automatic t_idle();
      idle_set_in = 1'h1;
      tick(1);
      idle_set_in = 1'h0;
      tick(3);
      `CHK({idle_request_bit_out, pc_run_out, periph_clk_en_out}, 3'h5)
      `CHK({addr_latch_strobe_out, program_store_strobe_n_out}, 2'h3)
      enabled_irq_in = 1'h1;
      tick(1);
      enabled_irq_in = 1'h0;
      `CHK({idle_request_bit_out, pc_run_out, wake_out}, 3'h3)
      tick(3);
      idle_set_in = 1'h1;
      tick(1);
      idle_set_in = 1'h0;
      tick(2);
      pulse_pin();
   endtask
   // Power-down ignores core interrupts; the level line wakes it, a pin reset ends it
   task automatic t_pd();
      addr_latch_strobe_core_in = 1'h1;
      pd_set_in = 1'h1;
      tick(1);
      pd_set_in = 1'h0;
      enabled_irq_in = 1'h1;
      tick(6);
      `CHK({powerdown_request_bit_out, core_clk_en_out, periph_clk_en_out}, 3'h4)
      `CHK({addr_latch_strobe_out, program_store_strobe_n_out}, 2'h0)
      enabled_irq_in = 1'h0;
      ext_level_irq_in = 1'h1;
      repeat (8) if (pc_run_out !== 1'h1) tick(1);
      `CHK({powerdown_request_bit_out, core_clk_en_out, pc_run_out, wake_out}, 4'h7)
      ext_level_irq_in = 1'h0;
      tick(6);
      pd_set_in = 1'h1;
      tick(1);
      pd_set_in = 1'h0;
      tick(2);
      pulse_pin();
   endtask
   // Stopped clock freezes the strobes; they move again once it returns
   task automatic t_standby();
      program_store_strobe_n_core_in = 1'h0;
      tick(3);
      gate <= 1'h1;
      tick(2);
      addr_latch_strobe_core_in = 1'h0;
      program_store_strobe_n_core_in = 1'h1;
      tick(6);
      `CHK({addr_latch_strobe_out, program_store_strobe_n_out, pc_run_out}, 3'h5)
      gate <= 1'h0;
      tick(3);
      `CHK({addr_latch_strobe_out, program_store_strobe_n_out, pc_run_out}, 3'h3)
   endtask
   //////////////////////////////////////////////////////////////////////////////
   task automatic finish_test();
      $display("errors=%0d compares=%0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      forever #2 osc_clk = ~osc_clk;
   end
   // Whole run needs a few hundred cycles; cut a hang well beyond that
   initial begin
      #40000;
      num_errors++;
      finish_test();
   end
   initial begin
      t_reset();
      t_ram();
      t_idle();
      t_pd();
      t_standby();
      finish_test();
   end
endmodule
`default_nettype wire
